// ### shared/fspb_consts.vh
// constants for the flash self-programming sequencer
// assumes a 10 MHz core clock and a 1 MHz calibrated rc time base
`ifndef FSPB_CONSTS_VH
`define FSPB_CONSTS_VH

// control register layout
`define FSPB_CTRL_ADDR 4'h0
`define FSPB_STAT_ADDR 4'h1
`define FSPB_BIT_SELFPROG_ENABLE 0
`define FSPB_BIT_ERASE 1
`define FSPB_BIT_WRITE 2
`define FSPB_BIT_LOCK 3
`define FSPB_BIT_REEN 4
`define FSPB_BIT_BUSY 6
`define FSPB_CTRL_RESET 8'h00
`define FSPB_LOAD_CODE 5'h01

// store must follow the control write within this many cycles
`define FSPB_ARM_CYCLES 3'h4

// strap settle: edges after release before the select is trusted
`define FSPB_STRAP_WAIT 2'h3

// write time in microseconds, rc oscillator period in ns
`define FSPB_TMIN_US 3700
`define FSPB_TMAX_US 4500
`define FSPB_RC_NS 1000
// rc ticks: min rounds up to whole ticks; pick the minimum
`define FSPB_PROG_TICKS ((`FSPB_TMIN_US * 1000 + `FSPB_RC_NS - 1) / `FSPB_RC_NS)

// address map in words
`define FSPB_RWW_LAST 12'hbff
`define FSPB_NO_CONCURRENT_READ_AREA_FIRST 12'hc00
`define FSPB_FLASH_LAST 12'hfff
`define FSPB_BOOT_11 12'hf80
`define FSPB_BOOT_10 12'hf00
`define FSPB_BOOT_01 12'he00
`define FSPB_BOOT_00 12'hc00

`endif

// ### design/fspb_rc_timer.v
// rc-based programming timer for the flash sequencer
// assumes rcTick is a one-cycle enable from the calibrated rc oscillator
`timescale 1ns/100ps
`default_nettype none

module fspb_rc_timer #(
    parameter TICKS = 3700
) (
    input wire clk,
    input wire rst_b,
    input wire start,
    input wire rcTick,
    output reg done_r
);
    reg [15:0] count_r;
    reg running_r;

    // count rc ticks, not core clocks
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count_r <= 16'h0000;
            running_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            if (start) begin
                count_r <= 16'h0000;
                running_r <= 1'b1;
            end else if (running_r && rcTick) begin
                // one tick past the last keeps us above the minimum
                if (count_r == TICKS[15:0]) begin
                    running_r <= 1'b0;
                    done_r <= 1'b1;
                end else begin
                    count_r <= count_r + 16'h0001;
                end
            end
        end
    end
endmodule

`default_nettype wire

// ### design/fspb_sequencer.v
// flash self-programming sequencer: control register, page buffer,
// z-pointer mapping, boot map and read-while-write gating
// assumes a core driving a plain register port and spm/lpm strobes
`timescale 1ns/100ps
`default_nettype none
`include "fspb_consts.vh"

module fspb_sequencer #(
    parameter PAGE_WORDS = 32,
    parameter PROG_TICKS = `FSPB_PROG_TICKS
) (
    input wire clk,
    input wire rst_b,
    input wire [3:0] regAddr,
    input wire [7:0] regWrData,
    input wire regWrStb,
    input wire regRdStb,
    output reg [7:0] regRdData_r,
    input wire rcTickPin,
    input wire [1:0] bootSizeSelPin,
    input wire eepromWriteActive,
    input wire spmStb,
    input wire lpmStb,
    input wire [15:0] zPtr,
    input wire [15:0] dataIn,
    input wire [11:0] fetchAddr,
    output reg [7:0] lpmData_r,
    output reg fetchAllowed_r,
    output reg [11:0] bootStart_r,
    output reg eraseReq_r,
    output reg writeReq_r,
    output reg [6:0] pageIndex_r,
    output reg [15:0] flashWrData_r,
    output reg [4:0] flashWrWord_r,
    output reg flashWrStb_r,
    output reg [11:0] flashRdAddr_r,
    input wire [15:0] flashRdData,
    input wire flashRdValid
);
    // one-hot sequencer states
    localparam ST_IDLE = 3'b001;
    localparam ST_ARMED = 3'b010;
    localparam ST_PROG = 3'b100;

    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg [7:0] ctrl_r;
    reg rwwBusy_r;
    reg [2:0] armCnt_r;
    reg [1:0] bootSel_r;
    reg bootSampled_r;
    reg [1:0] strapWait_r;
    reg rcSync1_r;
    reg rcSync2_r;
    reg rcSync3_r;
    reg [1:0] bszSync1_r;
    reg [1:0] bszSync2_r;
    reg [15:0] pageBuf_r [0:PAGE_WORDS-1];
    reg [PAGE_WORDS-1:0] bufValid_r;
    reg lpmLow_r;
    reg lpmPend_r;
    reg unloadOn_r;
    wire timerStart;
    wire timerDone;
    wire rcTick;
    wire ctrlWr;
    wire isProgCmd;
    wire progGo;
    wire loadGo;
    wire bufClear;
    wire [4:0] unloadNext;
    integer i;

    // boot start from the size select, top always 0xfff
    function [11:0] boot_start;
        input [1:0] sel;
        begin
            case (sel)
                2'b11: boot_start = `FSPB_BOOT_11;
                2'b10: boot_start = `FSPB_BOOT_10;
                2'b01: boot_start = `FSPB_BOOT_01;
                default: boot_start = `FSPB_BOOT_00;
            endcase
        end
    endfunction

    // true for words in the read-while-write area
    function in_rww;
        input [11:0] addr;
        begin
            in_rww = (addr <= `FSPB_RWW_LAST);
        end
    endfunction

    // rc tick and boot strap cross in through two flops
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rcSync1_r <= 1'b0;
            rcSync2_r <= 1'b0;
            rcSync3_r <= 1'b0;
            bszSync1_r <= 2'b00;
            bszSync2_r <= 2'b00;
        end else begin
            rcSync1_r <= rcTickPin;
            rcSync2_r <= rcSync1_r;
            rcSync3_r <= rcSync2_r;
            bszSync1_r <= bootSizeSelPin;
            bszSync2_r <= bszSync1_r;
        end
    end

    // rising edge of the synchronised rc clock
    assign rcTick = rcSync2_r & ~rcSync3_r;

    // strap caught once the synchroniser has settled, then frozen
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bootSel_r <= 2'b00;
            bootSampled_r <= 1'b0;
            strapWait_r <= 2'b00;
            bootStart_r <= `FSPB_BOOT_00;
        end else if (!bootSampled_r) begin
            // second flop still holds its reset value for the first edges
            if (strapWait_r == `FSPB_STRAP_WAIT) begin
                bootSel_r <= bszSync2_r;
                bootSampled_r <= 1'b1;
                bootStart_r <= boot_start(bszSync2_r);
            end else begin
                strapWait_r <= strapWait_r + 2'h1;
            end
        end
    end

    // writes refused while a timed op runs or eeprom writing
    assign ctrlWr = regWrStb && (regAddr == `FSPB_CTRL_ADDR) && (state_r != ST_PROG)
        && !eepromWriteActive;
    // erase, page write and lock write all run the timed sequence
    assign isProgCmd = ctrl_r[`FSPB_BIT_ERASE] || ctrl_r[`FSPB_BIT_WRITE]
        || ctrl_r[`FSPB_BIT_LOCK];
    assign progGo = (state_r == ST_ARMED) && spmStb && isProgCmd;
    assign loadGo = (state_r == ST_ARMED) && spmStb
        && (ctrl_r[4:0] == `FSPB_LOAD_CODE);
    assign timerStart = progGo;
    // buffer wipe after page write or rww reenable
    assign bufClear = (timerDone && ctrl_r[`FSPB_BIT_WRITE])
        || ((state_r == ST_ARMED) && spmStb && ctrl_r[`FSPB_BIT_REEN]);
    // next buffer word handed to the array
    assign unloadNext = flashWrWord_r + 5'h01;

    // next state
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (ctrlWr && regWrData[`FSPB_BIT_SELFPROG_ENABLE])
                    state_nxt = ST_ARMED;
            end
            ST_ARMED: begin
                if (progGo)
                    state_nxt = ST_PROG;
                else if (spmStb || armCnt_r == 3'h0)
                    state_nxt = ST_IDLE;
            end
            ST_PROG: begin
                if (timerDone)
                    state_nxt = ST_IDLE;
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // control register, arm window and busy flag
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= ST_IDLE;
            ctrl_r <= `FSPB_CTRL_RESET;
            armCnt_r <= 3'h0;
            rwwBusy_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (ctrlWr && state_r == ST_IDLE) begin
                ctrl_r <= {3'h0, regWrData[4:0]};
                armCnt_r <= `FSPB_ARM_CYCLES - 3'h1; // four-cycle window
            end else if (state_r == ST_ARMED && armCnt_r != 3'h0) begin
                armCnt_r <= armCnt_r - 3'h1;
            end
            // enable drops when the timed op ends or when the arm window closes without one
            if (state_r == ST_ARMED && state_nxt == ST_IDLE)
                ctrl_r <= `FSPB_CTRL_RESET;
            else if (state_r == ST_PROG && timerDone)
                ctrl_r <= `FSPB_CTRL_RESET;
            // set wins; lock write leaves rww readable
            if (progGo && !ctrl_r[`FSPB_BIT_LOCK])
                rwwBusy_r <= 1'b1;
            else if (state_r == ST_ARMED && spmStb && ctrl_r[`FSPB_BIT_REEN])
                rwwBusy_r <= 1'b0; // only once idle again
        end
    end

    fspb_rc_timer #(
        .TICKS(PROG_TICKS)
    ) u_timer (
        .clk(clk),
        .rst_b(rst_b),
        .start(timerStart),
        .rcTick(rcTick),
        .done_r(timerDone)
    );

    // temporary page buffer, write-once per word until cleared
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bufValid_r <= {PAGE_WORDS{1'b0}};
            for (i = 0; i < PAGE_WORDS; i = i + 1)
                pageBuf_r[i] <= 16'h0000;
        end else if (bufClear) begin
            bufValid_r <= {PAGE_WORDS{1'b0}};
            for (i = 0; i < PAGE_WORDS; i = i + 1)
                pageBuf_r[i] <= 16'hffff;
        end else if (loadGo && !bufValid_r[zPtr[5:1]]) begin
            // 32-word page on z[5:1], z[0] unused
            pageBuf_r[zPtr[5:1]] <= dataIn;
            bufValid_r[zPtr[5:1]] <= 1'b1;
        end
    end

    // flash array requests and buffer unload
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            eraseReq_r <= 1'b0;
            writeReq_r <= 1'b0;
            pageIndex_r <= 7'h00;
            flashWrData_r <= 16'h0000;
            flashWrWord_r <= 5'h00;
            flashWrStb_r <= 1'b0;
            unloadOn_r <= 1'b0;
        end else begin
            eraseReq_r <= progGo && ctrl_r[`FSPB_BIT_ERASE];
            writeReq_r <= progGo && ctrl_r[`FSPB_BIT_WRITE];
            if (progGo)
                pageIndex_r <= zPtr[12:6]; // z[15:13] dropped
            // stream buffer words to the array during a write
            flashWrStb_r <= 1'b0;
            // index and data leave together so the array sees a matched pair
            if (state_r == ST_PROG && unloadOn_r && rcTick) begin
                flashWrStb_r <= 1'b1;
                flashWrData_r <= pageBuf_r[unloadNext];
                flashWrWord_r <= unloadNext;
                if (unloadNext == 5'h1f)
                    unloadOn_r <= 1'b0; // one pass over the page only
            end else if (progGo) begin
                flashWrWord_r <= 5'h1f; // wraps to word 0 on the first tick
                unloadOn_r <= ctrl_r[`FSPB_BIT_WRITE];
            end
        end
    end

    // program read: byte select on z[0]
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flashRdAddr_r <= 12'h000;
            lpmLow_r <= 1'b0;
            lpmPend_r <= 1'b0;
            lpmData_r <= 8'h00;
        end else begin
            if (lpmStb) begin
                flashRdAddr_r <= zPtr[12:1]; // twelve-bit pc
                lpmLow_r <= ~zPtr[0];
                lpmPend_r <= 1'b1;
            end else if (lpmPend_r && flashRdValid) begin
                lpmPend_r <= 1'b0;
                lpmData_r <= lpmLow_r ? flashRdData[7:0] : flashRdData[15:8];
            end
        end
    end

    // fetch gate: rww blocked while busy, no_concurrent_read_area always open
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fetchAllowed_r <= 1'b1;
        end else begin
            fetchAllowed_r <= !(rwwBusy_r || progGo) || !in_rww(fetchAddr);
        end
    end

    // register reads, data one cycle after the strobe
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            regRdData_r <= 8'h00;
        end else if (regRdStb) begin
            case (regAddr)
                `FSPB_CTRL_ADDR:
                    regRdData_r <= {1'b0, rwwBusy_r, 1'b0, ctrl_r[4:0]};
                `FSPB_STAT_ADDR:
                    regRdData_r <= {6'h00, bootSel_r};
                default: regRdData_r <= 8'h00;
            endcase
        end else begin
            regRdData_r <= 8'h00;
        end
    end
endmodule

`default_nettype wire

// ### dv/fspb_seq_checker.sv
// port assertions for the flash sequencer
// assumes one clock and async active-low reset; bound below
`timescale 1ns/100ps
`default_nettype none
module fspb_seq_checker (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [3:0] regAddr,
    input wire logic regRdStb,
    input wire logic [7:0] regRdData_r,
    input wire logic spmStb,
    input wire logic lpmStb,
    input wire logic [15:0] zPtr,
    input wire logic [11:0] fetchAddr,
    input wire logic fetchAllowed_r,
    input wire logic [11:0] bootStart_r,
    input wire logic eraseReq_r,
    input wire logic [6:0] pageIndex_r,
    input wire logic [11:0] flashRdAddr_r
);
    logic [2:0] cnt_r;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // saturating age since reset; strap is sampled well before seven
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            cnt_r <= 3'h0;
        else if (cnt_r != 3'h7)
            cnt_r <= cnt_r + 3'h1;
    end
    a_read_idle:
        assert property ($past(!regRdStb) |-> regRdData_r == 8'h00) else $error("stray read data");
    a_no_concurrent_read_area_fetch:
        assert property ((&fetchAddr[11:10]) [*2] |-> fetchAllowed_r) else $error("no_concurrent_read_area blocked");
    a_boot_legal:
        assert property (bootStart_r inside {12'hc00, 12'he00, 12'hf00, 12'hf80})
        else $error("bad boot start");
    a_boot_held:
        assert property (cnt_r == 3'h7 |-> $stable(bootStart_r)) else $error("boot start moved");
    a_erase_page:
        assert property ($rose(eraseReq_r) |-> $past(spmStb) && pageIndex_r == $past(zPtr[12:6]))
        else $error("erase page wrong");
    a_erase_pulse:
        assert property (eraseReq_r |=> !eraseReq_r) else $error("erase request stuck");
    a_load_addr:
        assert property ($past(lpmStb) |-> flashRdAddr_r == $past(zPtr[12:1]))
        else $error("load address wrong");
    a_stat_map:
        assert property ($past(regRdStb && regAddr == 4'h1) && cnt_r == 3'h7
            |-> bootStart_r == 12'h000 - (12'h400 >> regRdData_r[1:0])) else $error("map wrong");
endmodule
bind fspb_sequencer fspb_seq_checker u_chk (.*);
`default_nettype wire

// ### dv/fspb_flash_model.sv
// flash array stand-in answering load reads
// assumes a read is launched by the load strobe
`timescale 1ns/100ps
`default_nettype none
module fspb_flash_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic lpmStb,
    input wire logic [11:0] flashRdAddr_r,
    output logic [15:0] flashRdData,
    output logic flashRdValid
);
    logic pend_r;
    // word content tracks its address; idle bus toggles so stale data shows
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pend_r <= 1'b0;
            flashRdValid <= 1'b0;
            flashRdData <= 16'h0000;
        end else begin
            pend_r <= lpmStb;
            flashRdValid <= pend_r;
            flashRdData <= pend_r ? {4'h5, flashRdAddr_r} : ~flashRdData;
        end
    end
endmodule
`default_nettype wire

// ### dv/flash_self_program_boot_map_test.sv
// self-checking bench for the flash sequencer
// assumes rc ticks every 1 us and the flash model on the read side
`timescale 1ns/100ps
`default_nettype none
module flash_self_program_boot_map_test;
    localparam T = 5;
    logic clk = 1'b0, rst_b = 1'b0, regWrStb = 1'b0, regRdStb = 1'b0, rcTickPin = 1'b0;
    logic eepromWriteActive = 1'b0, spmStb = 1'b0, lpmStb = 1'b0, flashRdValid;
    logic fetchAllowed_r, eraseReq_r, writeReq_r, flashWrStb_r;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWrData = 8'h00, regRdData_r, lpmData_r, v;
    logic [1:0] bootSizeSelPin = 2'h3;
    logic [15:0] zPtr = 16'h0000, dataIn = 16'h0000, flashRdData, flashWrData_r;
    logic [11:0] fetchAddr = 12'hc00, bootStart_r, flashRdAddr_r;
    logic [6:0] pageIndex_r;
    logic [4:0] flashWrWord_r;
    integer error_cnt = 0, comparisons = 0, cyc = 0;
    fspb_sequencer #(.PROG_TICKS(T)) u_dut (.*);
    fspb_flash_model u_mem (.*);
    always #50 clk = ~clk;
    // rc base edges land on falling clk edges, away from sampling
    always #500 rcTickPin = ~rcTickPin;
    task conclude;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
            if (error_cnt == 0 && comparisons > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    task chk(input [15:0] s, input [15:0] e);
        begin
            comparisons = comparisons + 1;
            if (s !== e) begin
                error_cnt = error_cnt + 1;
                $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
            end
        end
    endtask
    task wr(input [3:0] a, input [7:0] d);
        begin
            regAddr <= a;
            regWrData <= d;
            regWrStb <= 1'b1;
            @(posedge clk);
            regWrStb <= 1'b0;
        end
    endtask
    task rd(input [3:0] a);
        begin
            regAddr <= a;
            regRdStb <= 1'b1;
            @(posedge clk);
            regRdStb <= 1'b0;
            #1 v = regRdData_r;
            @(posedge clk);
        end
    endtask
    // no interrupt source is modelled: the core stand-in runs masked
    // control write then store in the very next cycle
    task op(input [7:0] c, input [15:0] z);
        begin
            wr(4'h0, c);
            zPtr <= z;
            spmStb <= 1'b1;
            @(posedge clk);
            spmStb <= 1'b0;
        end
    endtask
    task idle;
        integer n;
        begin
            v = 8'h01;
            for (n = 0; n < 300 && v[0] !== 1'b0; n = n + 1)
                rd(4'h0);
            chk({15'h0, v[0]}, 16'h0);
        end
    endtask
    task t_boot;
        integer i;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                bootSizeSelPin <= i[1:0];
                rst_b <= 1'b0;
                repeat (2) @(posedge clk);
                rst_b <= 1'b1;
                repeat (6) @(posedge clk);
                #1 chk({4'h0, bootStart_r}, 16'h1000 - (16'h0400 >> i));
                @(posedge clk);
                rd(4'h1);
                chk({14'h0, v[1:0]}, {14'h0, i[1:0]});
            end
            $display("boot map done");
        end
    endtask
    task t_erase;
        time t0;
        begin
            t0 = $time;
            fetchAddr <= 12'h100;
            op(8'h03, 16'he940);
            #1 chk({9'h0, pageIndex_r}, 16'h0025);
            repeat (2) @(posedge clk);
            #1 chk({15'h0, fetchAllowed_r}, 16'h0);
            @(posedge clk);
            rd(4'h0);
            chk({8'h0, v & 8'h41}, 16'h0041);
            idle;
            chk({15'h0, $time - t0 >= T * 1000}, 16'h1);
            chk({15'h0, $time - t0 <= T * 1500 + 3000}, 16'h1);
            chk({8'h0, v & 8'h40}, 16'h0040);
            op(8'h11, 16'h0000);
            idle;
            chk({8'h0, v & 8'h40}, 16'h0000);
            #1 chk({15'h0, fetchAllowed_r}, 16'h1);
            @(posedge clk);
            fetchAddr <= 12'hc00;
            $display("erase done");
        end
    endtask
    task t_write;
        integer n;
        logic hit;
        begin
            hit = 1'b0;
            dataIn <= 16'hbeef;
            op(8'h01, 16'h0946);
            idle;
            op(8'h05, 16'h0940);
            #1 chk({15'h0, writeReq_r}, 16'h1);
            for (n = 0; n < 600; n = n + 1) begin
                @(posedge clk);
                #1 if (flashWrStb_r === 1'b1 && flashWrWord_r === 5'h03) begin
                    chk(flashWrData_r, 16'hbeef);
                    hit = 1'b1;
                end
            end
            @(posedge clk);
            idle;
            op(8'h11, 16'h0000);
            idle;
            chk({15'h0, hit}, 16'h1);
            $display("page write done");
        end
    endtask
    task t_misc;
        integer i;
        begin
            for (i = 0; i < 2; i = i + 1) begin
                zPtr <= {15'h7003, i[0]};
                lpmStb <= 1'b1;
                @(posedge clk);
                lpmStb <= 1'b0;
                repeat (6) @(posedge clk);
                #1 chk({8'h0, lpmData_r}, i ? 16'h0050 : 16'h0003);
                @(posedge clk);
            end
            eepromWriteActive <= 1'b1;
            wr(4'h0, 8'h03);
            rd(4'h0);
            chk({8'h0, v}, 16'h0000);
            eepromWriteActive <= 1'b0;
            // lock write with the store on the last cycle of the window
            wr(4'h0, 8'h09);
            zPtr <= 16'h0000;
            repeat (3) @(posedge clk);
            spmStb <= 1'b1;
            @(posedge clk);
            spmStb <= 1'b0;
            rd(4'h0);
            chk({8'h0, v}, 16'h0009);
            idle;
            // store one cycle too late is dropped and the window closes
            wr(4'h0, 8'h03);
            repeat (4) @(posedge clk);
            spmStb <= 1'b1;
            @(posedge clk);
            spmStb <= 1'b0;
            rd(4'h0);
            chk({8'h0, v}, 16'h0000);
            $display("load and refusal done");
        end
    endtask
    // cut a hang short well past the expected run length
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            error_cnt = error_cnt + 1;
            conclude;
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_boot;
        t_erase;
        t_write;
        t_misc;
        conclude;
    end
endmodule
`default_nettype wire
